// ===== include/rtcpit_pkg.sv
// Constants for the real-time counter compare and periodic tick block.
// Assumes a 10 MHz mclk and APB with 32-bit data, one register per word.
`default_nettype none
package rtcpit_pkg;
    // ==========================================================
    // Clocking
    localparam int MCLK_HZ = 10000000;
    localparam int FAST_SRC_HZ = 32768;
    localparam int FAST_DIV_CYC = MCLK_HZ / FAST_SRC_HZ;
    localparam int SLOW_DIV_STEPS = 32;
    localparam int SYNC_TICKS = 2;

    // ==========================================================
    // Register indexes; byte address is four times the index
    localparam logic [4:0] IDX_INTCTRL = 5'h02;
    localparam logic [4:0] IDX_INTFLAGS = 5'h03;
    localparam logic [4:0] IDX_DEBUG = 5'h05;
    localparam logic [4:0] IDX_SRCSEL = 5'h07;
    localparam logic [4:0] IDX_TALLY_LO = 5'h08;
    localparam logic [4:0] IDX_TALLY_HI = 5'h09;
    localparam logic [4:0] IDX_MATCH_LO = 5'h0c;
    localparam logic [4:0] IDX_MATCH_HI = 5'h0d;
    localparam logic [4:0] IDX_TICK_CTRL = 5'h10;
    localparam logic [4:0] IDX_TICK_STAT = 5'h11;
    localparam logic [4:0] IDX_TICK_IEN = 5'h12;
    localparam logic [4:0] IDX_TICK_FLAG = 5'h13;

    // ==========================================================
    // Fields and reset values
    localparam int TICK_ON_BIT = 0;
    localparam int TICK_IVL_LSB = 3;
    localparam int TICK_IVL_MSB = 6;
    localparam int CMP_FLAG_BIT = 1;
    localparam logic [7:0] TICK_CTRL_MASK = 8'h79;
    localparam logic [7:0] TICK_CTRL_RST = 8'h00;
    localparam logic [15:0] MATCH_RST = 16'h0000;
    localparam logic [3:0] IVL_OFF = 4'h0;
    localparam logic [3:0] IVL_RESERVED = 4'hf;

    typedef enum logic [1:0] {
        RTCPIT_SRC_INT32K = 2'b00,
        RTCPIT_SRC_INT1K = 2'b01,
        RTCPIT_SRC_XTAL = 2'b10,
        RTCPIT_SRC_EXTPIN = 2'b11
    } rtcpit_src_t;
endpackage
`default_nettype wire

// ===== include/rtcpit_regbus_if.sv
// Byte-wide register port between the APB slave and the block core.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
`default_nettype none
interface rtcpit_regbus_if;
    logic wr;
    logic [4:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic hit;
    modport slave_side (output wr, output idx, output wdata, input rdata, input hit);
    modport core_side (input wr, input idx, input wdata, output rdata, output hit);
endinterface
`default_nettype wire

// ===== hw/rtcpit_apb.sv
// APB slave front end: decodes word addresses into register indexes.
// Assumes the core answers hit and rdata combinationally from idx.
`timescale 1ns/10ps
`default_nettype none
module rtcpit_apb (
    input wire logic mclk, // Block clock
    input wire logic rst, // Synchronous reset, high
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    rtcpit_regbus_if.slave_side rb // Core register port
);
    logic in_range;
    logic setup;
    logic miss;

    // ==========================================================
    // Decode
    assign in_range = (paddr[11:7] == 5'h00);
    assign rb.idx = paddr[6:2];
    assign rb.wdata = pwdata[7:0];
    assign setup = psel & ~penable;
    assign rb.wr = psel & penable & pwrite & in_range & rb.hit;
    // Zero wait states: read data is captured during setup
    assign pready = 1'b1;
    assign pslverr = psel & penable & miss;

    always_ff @(posedge mclk) begin
        if (rst) begin
            prdata <= 32'h00000000;
            miss <= 1'b0;
        end else if (setup) begin
            prdata <= {24'h000000, (in_range & rb.hit) ? rb.rdata : 8'h00};
            miss <= ~(in_range & rb.hit);
        end
    end
endmodule // rtcpit_apb
`default_nettype wire

// ===== hw/rtcpit_srcgen.sv
// Slow clock enable generator: one-cycle pulses at the selected rate.
// Assumes crystal and external clock pins are synchronous to mclk.
`timescale 1ns/10ps
`default_nettype none
module rtcpit_srcgen (
    input wire logic mclk, // Block clock
    input wire logic rst, // Synchronous reset, high
    input wire logic [1:0] src_sel, // Source select
    input wire logic xtal_clk, // Crystal or external clock level
    input wire logic ext_clk, // External clock pin level
    output logic slow_tick // One pulse per slow clock cycle
);
    logic [8:0] fast_cnt;
    logic [4:0] slow_cnt;
    logic fast_tick;
    logic xtal_q;
    logic ext_q;
    logic xtal_rise;
    logic ext_rise;

    assign fast_tick = (fast_cnt == 9'(rtcpit_pkg::FAST_DIV_CYC - 1));
    assign xtal_rise = xtal_clk & ~xtal_q;
    assign ext_rise = ext_clk & ~ext_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            fast_cnt <= 9'h000;
            slow_cnt <= 5'h00;
            xtal_q <= 1'b0;
            ext_q <= 1'b0;
        end else begin
            fast_cnt <= fast_tick ? 9'h000 : fast_cnt + 9'h001;
            if (fast_tick) begin
                slow_cnt <= slow_cnt + 5'h01;
            end
            xtal_q <= xtal_clk;
            ext_q <= ext_clk;
        end
    end

    always_comb begin
        unique case (rtcpit_pkg::rtcpit_src_t'(src_sel))
            rtcpit_pkg::RTCPIT_SRC_INT32K: slow_tick = fast_tick;
            // 1.024 kHz is the 32.768 kHz rate divided by 32
            rtcpit_pkg::RTCPIT_SRC_INT1K: slow_tick = fast_tick
                & (slow_cnt == 5'(rtcpit_pkg::SLOW_DIV_STEPS - 1));
            rtcpit_pkg::RTCPIT_SRC_XTAL: slow_tick = xtal_rise;
            rtcpit_pkg::RTCPIT_SRC_EXTPIN: slow_tick = ext_rise;
        endcase
    end
endmodule // rtcpit_srcgen
`default_nettype wire

// ===== hw/rtcpit_top.sv
// Real-time counter compare match and periodic tick timer with APB registers.
// Assumes synchronous pin inputs and a 10 MHz mclk; one clock domain only.
//
// Our own choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module rtcpit_top (
    input wire logic mclk, // Block clock, 10 MHz
    input wire logic rst, // Synchronous reset, high
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic cpu_halted, // CPU stopped in break debug
    input wire logic xtal_clk, // Crystal or external clock level
    input wire logic ext_clk, // External clock pin level
    output logic tick_irq, // Periodic interrupt request
    output logic irq // Combined interrupt, level
);
    rtcpit_regbus_if rb ();

    logic [15:0] match_value;
    logic [15:0] rtc_tally;
    logic [7:0] tick_control;
    logic [7:0] tick_applied;
    logic tick_sync_pending;
    logic [1:0] sync_cnt;
    logic tick_irq_enable;
    logic periodic_irq_flag;
    logic cmp_irq_enable;
    logic cmp_irq_flag;
    logic run_while_halted;
    logic [1:0] slow_clock_source;
    logic [14:0] pit_cnt;
    logic slow_tick;
    logic run_en;
    logic rtc_en;
    logic [3:0] ivl;
    logic ivl_valid;
    logic [14:0] ivl_last;
    logic pit_event;
    logic cmp_event;
    logic wr_match_lo;
    logic wr_match_hi;
    logic wr_ctrl;
    logic wr_ien;
    logic wr_flag;
    logic wr_intctrl;
    logic wr_intflags;
    logic wr_debug;
    logic wr_srcsel;
    logic sync_done;

    // ==========================================================
    // Bus front end and slow clock source
    rtcpit_apb u_apb (
        .mclk(mclk),
        .rst(rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .rb(rb.slave_side)
    );

    rtcpit_srcgen u_srcgen (
        .mclk(mclk),
        .rst(rst),
        .src_sel(slow_clock_source),
        .xtal_clk(xtal_clk),
        .ext_clk(ext_clk),
        .slow_tick(slow_tick)
    );

    // ==========================================================
    // Write decode
    assign wr_match_lo = rb.wr & (rb.idx == rtcpit_pkg::IDX_MATCH_LO);
    assign wr_match_hi = rb.wr & (rb.idx == rtcpit_pkg::IDX_MATCH_HI);
    assign wr_ctrl = rb.wr & (rb.idx == rtcpit_pkg::IDX_TICK_CTRL);
    assign wr_ien = rb.wr & (rb.idx == rtcpit_pkg::IDX_TICK_IEN);
    assign wr_flag = rb.wr & (rb.idx == rtcpit_pkg::IDX_TICK_FLAG);
    assign wr_intctrl = rb.wr & (rb.idx == rtcpit_pkg::IDX_INTCTRL);
    assign wr_intflags = rb.wr & (rb.idx == rtcpit_pkg::IDX_INTFLAGS);
    assign wr_debug = rb.wr & (rb.idx == rtcpit_pkg::IDX_DEBUG);
    assign wr_srcsel = rb.wr & (rb.idx == rtcpit_pkg::IDX_SRCSEL);

    // ==========================================================
    // Timing enables
    assign run_en = ~cpu_halted | run_while_halted;
    assign rtc_en = slow_tick & run_en;
    assign ivl = tick_applied[rtcpit_pkg::TICK_IVL_MSB:rtcpit_pkg::TICK_IVL_LSB];
    assign ivl_valid = (ivl != rtcpit_pkg::IVL_OFF) & (ivl != rtcpit_pkg::IVL_RESERVED);
    // Interval is 2^(code+1) slow cycles
    assign ivl_last = 15'((17'h00001 << (ivl + 4'h1)) - 17'h00001);
    assign pit_event = rtc_en & tick_applied[rtcpit_pkg::TICK_ON_BIT] & ivl_valid
        & (pit_cnt == ivl_last);
    assign cmp_event = rtc_en & (rtc_tally == match_value);
    assign sync_done = tick_sync_pending & slow_tick
        & (sync_cnt == 2'(rtcpit_pkg::SYNC_TICKS - 1));

    // ==========================================================
    // Software registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            match_value <= rtcpit_pkg::MATCH_RST;
            tick_control <= rtcpit_pkg::TICK_CTRL_RST;
            tick_irq_enable <= 1'b0;
            cmp_irq_enable <= 1'b0;
            run_while_halted <= 1'b0;
            slow_clock_source <= 2'b00;
        end else begin
            if (wr_match_lo) begin
                match_value[7:0] <= rb.wdata;
            end
            if (wr_match_hi) begin
                match_value[15:8] <= rb.wdata;
            end
            if (wr_ctrl) begin
                tick_control <= rb.wdata & rtcpit_pkg::TICK_CTRL_MASK;
            end
            if (wr_ien) begin
                tick_irq_enable <= rb.wdata[0];
            end
            if (wr_intctrl) begin
                cmp_irq_enable <= rb.wdata[rtcpit_pkg::CMP_FLAG_BIT];
            end
            if (wr_debug) begin
                run_while_halted <= rb.wdata[0];
            end
            if (wr_srcsel) begin
                slow_clock_source <= rb.wdata[1:0];
            end
        end
    end

    // ==========================================================
    // Control transfer into the slow domain
    // A new write restarts the count, so the last value always lands
    always_ff @(posedge mclk) begin
        if (rst) begin
            tick_sync_pending <= 1'b0;
            sync_cnt <= 2'b00;
            tick_applied <= rtcpit_pkg::TICK_CTRL_RST;
        end else if (wr_ctrl) begin
            tick_sync_pending <= 1'b1;
            sync_cnt <= 2'b00;
        end else if (sync_done) begin
            tick_sync_pending <= 1'b0;
            tick_applied <= tick_control;
        end else if (tick_sync_pending & slow_tick) begin
            sync_cnt <= sync_cnt + 2'b01;
        end
    end

    // ==========================================================
    // Tally and periodic interval counter
    always_ff @(posedge mclk) begin
        if (rst) begin
            rtc_tally <= 16'h0000;
            pit_cnt <= 15'h0000;
        end else begin
            if (rtc_en) begin
                rtc_tally <= rtc_tally + 16'h0001;
            end
            if (sync_done | ~tick_applied[rtcpit_pkg::TICK_ON_BIT]) begin
                pit_cnt <= 15'h0000;
            end else if (rtc_en) begin
                pit_cnt <= (pit_cnt == ivl_last) ? 15'h0000 : pit_cnt + 15'h0001;
            end
        end
    end

    // ==========================================================
    // Sticky flags: a new event wins over a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            periodic_irq_flag <= 1'b0;
            cmp_irq_flag <= 1'b0;
        end else begin
            if (pit_event) begin
                periodic_irq_flag <= 1'b1;
            end else if (wr_flag & rb.wdata[0]) begin
                periodic_irq_flag <= 1'b0;
            end
            if (cmp_event) begin
                cmp_irq_flag <= 1'b1;
            end else if (wr_intflags & rb.wdata[rtcpit_pkg::CMP_FLAG_BIT]) begin
                cmp_irq_flag <= 1'b0;
            end
        end
    end

    assign tick_irq = periodic_irq_flag & tick_irq_enable;
    assign irq = tick_irq | (cmp_irq_flag & cmp_irq_enable);

    // ==========================================================
    // Read decode
    always_comb begin
        rb.hit = 1'b1;
        unique case (rb.idx)
            rtcpit_pkg::IDX_INTCTRL: rb.rdata = {6'h00, cmp_irq_enable, 1'b0};
            rtcpit_pkg::IDX_INTFLAGS: rb.rdata = {6'h00, cmp_irq_flag, 1'b0};
            rtcpit_pkg::IDX_DEBUG: rb.rdata = {7'h00, run_while_halted};
            rtcpit_pkg::IDX_SRCSEL: rb.rdata = {6'h00, slow_clock_source};
            rtcpit_pkg::IDX_TALLY_LO: rb.rdata = rtc_tally[7:0];
            rtcpit_pkg::IDX_TALLY_HI: rb.rdata = rtc_tally[15:8];
            rtcpit_pkg::IDX_MATCH_LO: rb.rdata = match_value[7:0];
            rtcpit_pkg::IDX_MATCH_HI: rb.rdata = match_value[15:8];
            rtcpit_pkg::IDX_TICK_CTRL: rb.rdata = tick_control;
            rtcpit_pkg::IDX_TICK_STAT: rb.rdata = {7'h00, tick_sync_pending};
            rtcpit_pkg::IDX_TICK_IEN: rb.rdata = {7'h00, tick_irq_enable};
            rtcpit_pkg::IDX_TICK_FLAG: rb.rdata = {7'h00, periodic_irq_flag};
            default: begin
                rb.rdata = 8'h00;
                rb.hit = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_ctrl_write;
        wr_ctrl;
    endsequence
    sequence s_pending_two_ticks;
        tick_sync_pending [*2];
    endsequence

    AST_MATCH_LO_WRITE: assert property (
        wr_match_lo |=> match_value[7:0] == $past(rb.wdata))
        else $error("match low byte not stored");
    AST_MATCH_HI_KEEPS_LO: assert property (
        wr_match_hi && !wr_match_lo |=> match_value[7:0] == $past(match_value[7:0]))
        else $error("high byte write disturbed low byte");
    AST_OFF_CODES_SILENT: assert property (
        !ivl_valid |-> !pit_event)
        else $error("tick from off or reserved interval");
    AST_DISABLED_SILENT: assert property (
        !tick_applied[rtcpit_pkg::TICK_ON_BIT] |-> !pit_event)
        else $error("tick while timer off");
    AST_BUSY_AFTER_WRITE: assert property (
        s_ctrl_write |=> s_pending_two_ticks)
        else $error("busy not held after control write");
    AST_FLAG_ON_EVENT: assert property (
        pit_event |=> periodic_irq_flag)
        else $error("periodic flag not set");
    AST_W1C_CLEARS: assert property (
        wr_flag && rb.wdata[0] && !pit_event |=> !periodic_irq_flag)
        else $error("periodic flag not cleared");
    AST_W0_KEEPS: assert property (
        periodic_irq_flag && wr_flag && !rb.wdata[0] |=> periodic_irq_flag)
        else $error("zero write cleared periodic flag");
    AST_HALT_FREEZES: assert property (
        cpu_halted && !run_while_halted |=> rtc_tally == $past(rtc_tally) && !$past(pit_event))
        else $error("timer ran while halted");
    AST_CMP_MATCH: assert property (
        rtc_en && rtc_tally == match_value |=> cmp_irq_flag)
        else $error("compare flag not set on match");
    AST_REQ_FOLLOWS: assert property (
        $rose(periodic_irq_flag) && tick_irq_enable |-> tick_irq && irq)
        else $error("periodic request not raised");
endmodule // rtcpit_top
`default_nettype wire

// ===== testbench/rtc_compare_periodic_tick_tb.sv
// Self-checking bench for the compare match and periodic tick block.
// Assumes rtcpit_top with zero-wait APB; slow clocks are made here from mclk.
`timescale 1ns/10ps
`default_nettype none
module rtc_compare_periodic_tick_tb;
    // ==========================================================
    // Stimulus and clocks
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic cpu_halted = 1'b0;
    logic xtal_clk = 1'b0;
    logic ext_clk = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic tick_irq;
    logic irq;
    logic [2:0] sdiv = 3'h0;
    int cyc = 0;
    int n_errors = 0;
    int n_compared = 0;
    // Rows: byte address, write byte, expected read back
    localparam logic [27:0] ROWS [14] = '{28'h030_a5_a5, 28'h034_5a_5a, 28'h030_ff_ff,
        28'h034_00_00, 28'h048_ff_01, 28'h008_ff_02, 28'h014_ff_01, 28'h01c_01_01,
        28'h01c_02_02, 28'h01c_03_03, 28'h01c_00_00, 28'h044_ff_00, 28'h024_ff_00,
        28'h040_ff_79};
    localparam logic [11:0] RST_ADDR [12] = '{12'h008, 12'h00c, 12'h014, 12'h01c, 12'h020,
        12'h024, 12'h030, 12'h034, 12'h040, 12'h044, 12'h048, 12'h04c};
    // Source nibble, interval code nibble
    localparam logic [7:0] PERIODS [9] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26,
        8'h31, 8'h32, 8'h01};

    always #50 mclk = ~mclk;

    // Crystal pin rises every 4 mclk, external pin every 8
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        sdiv <= sdiv + 3'h1;
        xtal_clk <= sdiv[1];
        ext_clk <= sdiv[2];
    end

    rtcpit_top u_dut (
        .mclk(mclk),
        .rst(rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .cpu_halted(cpu_halted),
        .xtal_clk(xtal_clk),
        .ext_clk(ext_clk),
        .tick_irq(tick_irq),
        .irq(irq)
    );

    // ==========================================================
    // Shared tasks
    task automatic results();
        if (n_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Idle edge first, so psel never changes twice in one time step
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
            output logic [31:0] q, output logic e);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge mclk);
        penable <= 1'b1;
        // Wait states are left to the slave; only the watchdog ends a hang
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        chk("pready", {31'h0, pready}, 32'h00000001);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 8'h00, q, e);
    endtask

    task automatic wait_busy();
        logic [31:0] q;
        int k;
        k = 0;
        do begin
            rd(12'h044, q);
            k++;
        end while (q[0] !== 1'b0 && k < 1000);
        chk("sync pending", q, 32'h00000000);
    endtask

    task automatic wait_rise(input int lim, input logic use_irq, output logic f);
        f = 1'b0;
        for (int i = 0; i < lim && !f; i++) begin
            @(posedge mclk);
            f = ((use_irq ? irq : tick_irq) === 1'b1);
        end
    endtask

    task automatic chk_reset();
        logic [31:0] q;
        chk("tick_irq", {31'h0, tick_irq}, 32'h00000000);
        chk("irq", {31'h0, irq}, 32'h00000000);
        foreach (RST_ADDR[i]) begin
            rd(RST_ADDR[i], q);
            chk("reset value", q, 32'h00000000);
        end
    endtask

    initial begin
        repeat (60000) @(posedge mclk);
        n_errors++;
        results();
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] q;
        logic [31:0] t;
        logic e;
        logic f;
        int t0;
        int ex;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        chk_reset();
        foreach (ROWS[i]) begin
            wr(ROWS[i][27:16], ROWS[i][15:8]);
            rd(ROWS[i][27:16], q);
            chk("row read back", q, {24'h0, ROWS[i][7:0]});
        end
        wait_busy();
        wr(12'h008, 8'h00);
        wr(12'h014, 8'h00);
        // Unmapped word indexes answer with an error and zero data
        apb(1'b0, 12'h018, 8'h00, q, e);
        chk("unmapped read", {q[30:0], e}, 32'h00000001);
        apb(1'b1, 12'h07c, 8'hff, q, e);
        chk("unmapped write", {31'h0, e}, 32'h00000001);
        // Interval between two successive ticks, per source and code
        foreach (PERIODS[i]) begin
            ex = (PERIODS[i][7:4] == 4'h0) ? rtcpit_pkg::FAST_DIV_CYC :
                ((PERIODS[i][7:4] == 4'h2) ? 4 : 8);
            ex = ex * (1 << (PERIODS[i][3:0] + 1));
            wr(12'h01c, PERIODS[i][7:0] >> 4);
            wr(12'h040, {1'b0, PERIODS[i][3:0], 3'b001});
            rd(12'h044, q);
            chk("sync pending after write", q, 32'h00000001);
            wait_busy();
            wr(12'h04c, 8'h01);
            wait_rise(ex + 50, 1'b0, f);
            t0 = cyc;
            wr(12'h04c, 8'h01);
            wait_rise(ex + 50, 1'b0, f);
            chk("tick seen", {31'h0, f}, 32'h00000001);
            chk("tick interval", cyc - t0, ex);
        end
        // Code off, reserved code, and timer switched off give no tick
        // Fast crystal source, so a wrong decode would tick inside the wait
        wr(12'h01c, 8'h02);
        foreach (PERIODS[i]) begin
            if (i < 3) begin
                wr(12'h040, (i == 0) ? 8'h01 : ((i == 1) ? 8'h79 : 8'h08));
                wait_busy();
                wr(12'h04c, 8'h01);
                wait_rise(600, 1'b0, f);
                chk("no tick", {31'h0, f}, 32'h00000000);
            end
        end
        // Sticky flag, write-one-to-clear, enable gating
        wr(12'h01c, 8'h02);
        wr(12'h040, 8'h09);
        wait_busy();
        wait_rise(100, 1'b0, f);
        wr(12'h040, 8'h00);
        wait_busy();
        rd(12'h04c, q);
        chk("tick flag set", q, 32'h00000001);
        wr(12'h048, 8'h00);
        rd(12'h04c, q);
        chk("gated tick_irq", {31'h0, tick_irq, irq}, 32'h00000000);
        wr(12'h04c, 8'h00);
        rd(12'h04c, q);
        chk("flag after zero", q, 32'h00000001);
        wr(12'h04c, 8'h01);
        rd(12'h04c, q);
        chk("flag after one", q, 32'h00000000);
        // Halt freezes the tick and the tally; compare fires after release
        cpu_halted <= 1'b1;
        wr(12'h040, 8'h09);
        wait_busy();
        wr(12'h04c, 8'h01);
        wr(12'h048, 8'h01);
        wait_rise(300, 1'b0, f);
        chk("tick while halted", {31'h0, f}, 32'h00000000);
        rd(12'h020, t);
        rd(12'h024, q);
        t = {16'h0000, q[7:0], t[7:0]} + 32'h00000006;
        rd(12'h020, q);
        chk("tally frozen", q, {24'h0, t[7:0] - 8'h06});
        wr(12'h048, 8'h00);
        wr(12'h030, t[7:0]);
        wr(12'h034, t[15:8]);
        wr(12'h00c, 8'h02);
        wr(12'h008, 8'h02);
        cpu_halted <= 1'b0;
        wait_rise(200, 1'b1, f);
        chk("compare irq", {31'h0, f}, 32'h00000001);
        rd(12'h00c, q);
        chk("compare flag", q, 32'h00000002);
        wr(12'h00c, 8'h02);
        rd(12'h00c, q);
        chk("compare cleared", {q[30:0], irq}, 32'h00000000);
        // One 1.024 kHz tick spans 32 of the 32.768 kHz ticks
        wr(12'h01c, 8'h01);
        rd(12'h020, t);
        repeat (rtcpit_pkg::FAST_DIV_CYC * rtcpit_pkg::SLOW_DIV_STEPS - 3) @(posedge mclk);
        rd(12'h020, q);
        chk("slow source rate", {24'h0, q[7:0] - t[7:0]}, 32'h00000001);
        wr(12'h01c, 8'h02);
        // Run-while-halted keeps the tick going
        wr(12'h014, 8'h01);
        cpu_halted <= 1'b1;
        wr(12'h04c, 8'h01);
        wr(12'h048, 8'h01);
        wait_rise(100, 1'b0, f);
        chk("tick halted run", {31'h0, f}, 32'h00000001);
        cpu_halted <= 1'b0;
        // Second reset with the request high
        rst <= 1'b1;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        chk_reset();
        results();
    end
endmodule // rtc_compare_periodic_tick_tb
`default_nettype wire
